// ### src/chbp_dev_end.sv
`timescale 1ns/100ps
module chbp_dev_end import chbp_pkg::*; #(
  parameter int ADDR_W = CHBP_ADDR_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host bus pins
  chbp_if.dev bus,
  // Options
  input wire logic i_strobe_pair_mode,
  input wire logic i_ack_delay_select,
  // Service request state
  input wire logic i_svc_pending,
  input wire logic [CHBP_CMP_W-1:0] i_svc_match_value,
  input wire logic [7:0] i_svc_vector,
  // Internal register port
  input wire logic [7:0] i_reg_rdata,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [ADDR_W-1:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_busy
);
  chbp_dstate_t state_reg;
  chbp_dstate_t state_next;
  logic phase_reg;
  logic is_ack_reg;
  logic is_write_reg;
  logic pullup_reg;
  logic strobe;
  logic dir_write;
  logic sel_cycle;
  logic ack_qual;
  logic cmp_valid;
  logic cmp_hit;
  logic enter_arb;
  logic enter_xfer;
  logic ack_on;
  logic pass_next;

  if (ADDR_W < CHBP_CMP_W) begin : g_bad_width
    $error("ADDR_W must be at least the comparator width");
  end

  // Strobe and direction decode for both handshake styles
  function automatic logic strobe_on(input logic pair, input logic ds_n, input logic rd_n, input logic wr_n);
    strobe_on = pair ? ~(rd_n & wr_n) : ~ds_n;
  endfunction

  function automatic logic write_on(input logic pair, input logic rw_n, input logic wr_n);
    write_on = pair ? ~wr_n : ~rw_n;
  endfunction

  assign strobe = strobe_on(i_strobe_pair_mode, bus.ds_n, bus.rd_n, bus.wr_n);
  assign dir_write = write_on(i_strobe_pair_mode, bus.rw_n, bus.wr_n);
  assign sel_cycle = ~bus.cs_n & strobe & bus.ack_chain_in_n;
  assign ack_qual = ~bus.ack_chain_in_n & strobe;

  chbp_svc_cmp #(.CMP_W(CHBP_CMP_W)) u_cmp (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(ack_qual && state_reg == CHBP_D_CMP),
    .i_addr(bus.addr[CHBP_CMP_W-1:0]),
    .i_match_value(i_svc_match_value),
    .i_pending(i_svc_pending),
    .o_valid(cmp_valid),
    .o_hit(cmp_hit)
  );

  // Device clock: high when phase_reg is set, falls when it clears
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_reg <= 1'b0;
      bus.clock_fwd_out <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      bus.clock_fwd_out <= ~phase_reg;
    end
  end

  // Cycle machine; recognition only where the device clock falls
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CHBP_D_IDLE: begin
        if (sel_cycle && phase_reg) begin
          state_next = CHBP_D_ARB;
        end else if (ack_qual) begin
          state_next = CHBP_D_CMP;
        end
      end
      CHBP_D_CMP: begin
        if (!ack_qual) begin
          state_next = CHBP_D_IDLE;
        end else if (cmp_valid && !cmp_hit) begin
          state_next = CHBP_D_PASS;
        end else if (cmp_valid && phase_reg) begin
          state_next = CHBP_D_ARB;
        end
      end
      CHBP_D_ARB: begin
        state_next = CHBP_D_XFER;
      end
      CHBP_D_XFER: begin
        state_next = i_ack_delay_select ? CHBP_D_DLY : CHBP_D_HOLD;
      end
      CHBP_D_DLY: begin
        state_next = CHBP_D_HOLD;
      end
      CHBP_D_HOLD: begin
        if (!strobe) begin
          state_next = CHBP_D_IDLE;
        end
      end
      CHBP_D_PASS: begin
        if (bus.ack_chain_in_n || !strobe) begin
          state_next = CHBP_D_IDLE;
        end
      end
      default: begin
        state_next = CHBP_D_IDLE;
      end
    endcase
  end

  assign enter_arb = (state_next == CHBP_D_ARB) && (state_reg != CHBP_D_ARB);
  assign enter_xfer = (state_reg == CHBP_D_ARB);
  // Ack after rising edge, or after the next falling edge when delayed
  assign ack_on = (enter_xfer && !i_ack_delay_select) || (state_reg == CHBP_D_XFER && i_ack_delay_select);
  // Pass chain activity on before the strobe and after a compare miss; held off while comparing or once taken
  assign pass_next = ~(((state_reg == CHBP_D_IDLE) && !bus.ack_chain_in_n && !strobe)
                       || (state_next == CHBP_D_PASS));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= CHBP_D_IDLE;
      o_busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      o_busy <= (state_next != CHBP_D_IDLE);
    end
  end

  // Cycle type latched as the internal bus is taken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      is_ack_reg <= 1'b0;
      is_write_reg <= 1'b0;
    end else if (enter_arb) begin
      is_ack_reg <= (state_reg == CHBP_D_CMP);
      is_write_reg <= dir_write && (state_reg == CHBP_D_IDLE);
    end
  end

  // Internal register port: read in low phase, write in high phase
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_addr <= '0;
      o_reg_rd <= 1'b0;
      o_reg_wr <= 1'b0;
      o_reg_wdata <= 8'h00;
    end else begin
      o_reg_rd <= enter_arb && (state_reg == CHBP_D_IDLE) && !dir_write;
      o_reg_wr <= enter_xfer && is_write_reg;
      if (enter_arb) begin
        o_reg_addr <= bus.addr;
      end
      if (enter_xfer) begin
        o_reg_wdata <= bus.data;
      end
    end
  end

  // Read data from the transfer phase until the strobe goes away
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus.dev_data_out <= 8'h00;
      bus.dev_data_oe <= 1'b0;
    end else if (enter_xfer && !is_write_reg) begin
      bus.dev_data_out <= is_ack_reg ? i_svc_vector : i_reg_rdata;
      bus.dev_data_oe <= 1'b1;
    end else if (!strobe || state_reg == CHBP_D_IDLE || state_reg == CHBP_D_PASS) begin
      bus.dev_data_oe <= 1'b0;
    end
  end

  // Open-drain ack, driven high one cycle before release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus.dev_ack_out_n <= 1'b1;
      bus.dev_ack_oe <= 1'b0;
      pullup_reg <= 1'b0;
    end else if (ack_on) begin
      bus.dev_ack_out_n <= 1'b0;
      bus.dev_ack_oe <= 1'b1;
      pullup_reg <= 1'b0;
    end else if (!bus.dev_ack_out_n && !strobe) begin
      bus.dev_ack_out_n <= 1'b1;
      pullup_reg <= 1'b1;
    end else if (pullup_reg) begin
      bus.dev_ack_oe <= 1'b0;
      pullup_reg <= 1'b0;
    end
  end

  // Chain output follows input while this device declines
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus.ack_chain_pass_n <= 1'b1;
    end else begin
      bus.ack_chain_pass_n <= pass_next;
    end
  end
endmodule

// ### src/chbp_host_end.sv
`timescale 1ns/100ps
module chbp_host_end import chbp_pkg::*; #(
  parameter int ADDR_W = CHBP_ADDR_W,
  parameter int ACK_WAIT_CYC = CHBP_ACK_WAIT_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Device bus pins
  chbp_if.host bus,
  // Request port
  input wire logic i_strobe_pair_mode,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_svc,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_done,
  output logic o_timeout,
  output logic [7:0] o_rdata
);
  chbp_hstate_t state_reg;
  chbp_hstate_t state_next;
  logic [15:0] wait_reg;
  logic write_reg;
  logic svc_reg;
  logic expired;

  if (ACK_WAIT_CYC < 2 || ACK_WAIT_CYC > 65535) begin : g_bad_wait
    $error("ACK_WAIT_CYC out of range");
  end

  assign expired = (wait_reg == 16'h0000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CHBP_H_IDLE: begin
        if (i_req_valid) begin
          state_next = CHBP_H_SETUP;
        end
      end
      CHBP_H_SETUP: begin
        state_next = CHBP_H_STROBE;
      end
      CHBP_H_STROBE: begin
        if (!bus.transfer_ack_n || expired) begin
          state_next = CHBP_H_RELEASE;
        end
      end
      CHBP_H_RELEASE: begin
        if (bus.transfer_ack_n) begin
          state_next = CHBP_H_GAP;
        end
      end
      CHBP_H_GAP: begin
        state_next = CHBP_H_IDLE;
      end
      default: begin
        state_next = CHBP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= CHBP_H_IDLE;
      o_req_ready <= 1'b0;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      o_rdata <= 8'h00;
      wait_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      o_req_ready <= (state_next == CHBP_H_IDLE);
      o_done <= (state_reg == CHBP_H_GAP);
      o_timeout <= (state_reg == CHBP_H_STROBE) && expired && bus.transfer_ack_n;
      if (state_reg == CHBP_H_SETUP) begin
        wait_reg <= ACK_WAIT_CYC[15:0];
      end else if (!expired) begin
        wait_reg <= wait_reg - 16'h0001;
      end
      if (state_reg == CHBP_H_STROBE && !bus.transfer_ack_n && !write_reg) begin
        o_rdata <= bus.data; // Data captured before strobe removal
      end
    end
  end

  // Request fields stay put for the whole cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      write_reg <= 1'b0;
      svc_reg <= 1'b0;
      bus.addr <= '0;
      bus.host_data_out <= 8'h00;
    end else if (state_reg == CHBP_H_IDLE && i_req_valid) begin
      write_reg <= i_req_write && !i_req_svc;
      svc_reg <= i_req_svc;
      bus.addr <= i_req_addr;
      bus.host_data_out <= i_req_wdata;
    end
  end

  // Pin levels: all idle outside the strobe state
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus.cs_n <= 1'b1;
      bus.ds_n <= 1'b1;
      bus.rw_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.ack_chain_in_n <= 1'b1;
      bus.host_data_oe <= 1'b0;
    end else begin
      // Direction waits for the latched request, so a stale write never shows in setup
      bus.rw_n <= !(write_reg && state_next == CHBP_H_STROBE);
      bus.host_data_oe <= write_reg && state_next == CHBP_H_STROBE;
      if (state_next == CHBP_H_STROBE) begin
        bus.cs_n <= svc_reg;
        bus.ack_chain_in_n <= !svc_reg;
        bus.ds_n <= i_strobe_pair_mode;
        bus.rd_n <= !(i_strobe_pair_mode && !write_reg);
        bus.wr_n <= !(i_strobe_pair_mode && write_reg);
      end else begin
        bus.cs_n <= 1'b1;
        bus.ack_chain_in_n <= 1'b1;
        bus.ds_n <= 1'b1;
        bus.rd_n <= 1'b1;
        bus.wr_n <= 1'b1;
      end
    end
  end
endmodule

// ### src/chbp_if.sv
`timescale 1ns/100ps
interface chbp_if #(parameter int ADDR_W = 8);
  logic cs_n;
  logic ds_n;
  logic rw_n;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] addr;
  logic [7:0] host_data_out;
  logic host_data_oe;
  logic [7:0] dev_data_out;
  logic dev_data_oe;
  logic [7:0] data;
  logic dev_ack_out_n;
  logic dev_ack_oe;
  logic transfer_ack_n;
  logic ack_chain_in_n;
  logic ack_chain_pass_n;
  logic clock_fwd_out;

  // Shared data bus and pulled-up open-drain acknowledge
  assign data = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);
  assign transfer_ack_n = dev_ack_oe ? dev_ack_out_n : 1'b1;

  modport dev (
    input cs_n, ds_n, rw_n, rd_n, wr_n, addr, data, ack_chain_in_n,
    output dev_data_out, dev_data_oe, dev_ack_out_n, dev_ack_oe, ack_chain_pass_n, clock_fwd_out
  );
  modport host (
    input data, transfer_ack_n, ack_chain_pass_n, clock_fwd_out,
    output cs_n, ds_n, rw_n, rd_n, wr_n, addr, host_data_out, host_data_oe, ack_chain_in_n
  );
endinterface

// ### src/chbp_pkg.sv
// Function
// - Start cycle on falling edge, select and strobe low
// - Late select or strobe starts one clock later
// - Acquire internal bus in the low phase
// - Transfer in high phase, cycle then complete
// - Host sets address and data before transfer
// - Read data driven from transfer-phase rising edge
// - Acknowledge cycle reads the service request vector
// - Acknowledge address through 8-bit comparator and state
// - No match: pass chain, no data, no ack
// - Chain input passes through, released at end
// - Host holds chain input low long enough
// - Host holds controls until transfer acknowledge
// - Host idles all controls between cycles
// - Delay option moves ack past falling edge
// - Release data and ack after strobe negation
// - Host holds reset five clock periods; the testbench releases it after six system clocks, three device clocks
// - Strobe-direction or separate read/write strobes
// - Forwarded clock output for chained devices
package chbp_pkg;
  localparam int CHBP_ADDR_W = 8;
  localparam int CHBP_DATA_W = 8;
  localparam int CHBP_CMP_W = 8;
  localparam int CHBP_CLK_NS = 10;
  localparam int CHBP_RST_PERIODS = 5;
  // Device clock is two system clocks long
  localparam int CHBP_DEV_CLK_CYC = 2;
  localparam int CHBP_RST_CYC = CHBP_RST_PERIODS * CHBP_DEV_CLK_CYC;
  // Host gives up waiting for acknowledge after this long
  localparam int CHBP_ACK_WAIT_NS = 2000;
  localparam int CHBP_ACK_WAIT_CYC = CHBP_ACK_WAIT_NS / CHBP_CLK_NS;
  localparam logic [7:0] CHBP_BUS_IDLE = 8'hff;

  typedef enum logic [6:0] {
    CHBP_D_IDLE = 7'h01,
    CHBP_D_CMP = 7'h02,
    CHBP_D_ARB = 7'h04,
    CHBP_D_XFER = 7'h08,
    CHBP_D_DLY = 7'h10,
    CHBP_D_HOLD = 7'h20,
    CHBP_D_PASS = 7'h40
  } chbp_dstate_t;

  typedef enum logic [4:0] {
    CHBP_H_IDLE = 5'h01,
    CHBP_H_SETUP = 5'h02,
    CHBP_H_STROBE = 5'h04,
    CHBP_H_RELEASE = 5'h08,
    CHBP_H_GAP = 5'h10
  } chbp_hstate_t;
endpackage

// ### src/chbp_svc_cmp.sv
`timescale 1ns/100ps
module chbp_svc_cmp import chbp_pkg::*; #(
  parameter int CMP_W = CHBP_CMP_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Compare request
  input wire logic i_start,
  input wire logic [CMP_W-1:0] i_addr,
  input wire logic [CMP_W-1:0] i_match_value,
  input wire logic i_pending,
  // Registered result
  output logic o_valid,
  output logic o_hit
);
  // One registered stage decouples the wide compare from the cycle machine
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_hit <= 1'b0;
    end else begin
      o_valid <= i_start;
      o_hit <= i_start & i_pending & (i_addr == i_match_value);
    end
  end
endmodule

// ### verification/chbp_props.sv
`timescale 1ns/100ps
module chbp_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Host side pins
  input wire logic cs_n,
  input wire logic ds_n,
  input wire logic rw_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ack_chain_in_n,
  // Device side pins
  input wire logic transfer_ack_n,
  input wire logic dev_data_oe,
  input wire logic ack_chain_pass_n,
  input wire logic clock_fwd_out
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Any strobe active, either handshake style
  wire strb = !ds_n || !rd_n || !wr_n;
  wire rd_cyc = (!ds_n && rw_n) || !rd_n;
  wire sel = !cs_n && strb && ack_chain_in_n;

  // Ack stays off on the take edge, lands within the delay options
  sequence s_ans;
    transfer_ack_n ##[1:4] !transfer_ack_n;
  endsequence
  sequence s_late;
    transfer_ack_n ##1 s_ans;
  endsequence

  chk_take_early: assert property ($rose(sel) && clock_fwd_out |-> s_ans)
    else $error("no ack after early take");
  chk_take_late: assert property ($rose(sel) && !clock_fwd_out |-> s_late)
    else $error("late take not one clock later");
  chk_ack_strobe: assert property ($fell(transfer_ack_n) |-> strb)
    else $error("ack without strobe");
  chk_ack_holds: assert property (!transfer_ack_n && strb |=> !transfer_ack_n)
    else $error("ack dropped while strobe held");
  chk_ack_release: assert property ($rose(!strb) |-> ##[0:2] transfer_ack_n)
    else $error("ack not negated after strobe");
  chk_data_release: assert property ($rose(!strb) |-> ##[0:2] !dev_data_oe)
    else $error("data bus still driven");
  chk_read_data: assert property ($fell(transfer_ack_n) && rd_cyc |-> dev_data_oe)
    else $error("read ack without data");
  chk_miss_quiet: assert property (!ack_chain_pass_n |-> transfer_ack_n && !dev_data_oe)
    else $error("passing device drives bus");
  chk_pass_release: assert property ($rose(ack_chain_in_n) |-> ##[0:2] ack_chain_pass_n)
    else $error("chain output not released");
  chk_pass_cause: assert property (!ack_chain_pass_n |-> !$past(ack_chain_in_n))
    else $error("chain output low without input");
  chk_fwd_clock: assert property (!$past(i_rst) |-> clock_fwd_out != $past(clock_fwd_out))
    else $error("forwarded clock not toggling");
endmodule

// ### verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic mode = 1'b0;
  logic dly = 1'b0;
  logic pend = 1'b0;
  logic [7:0] match = 8'h00;
  logic valid = 1'b0;
  logic wr = 1'b0;
  logic svc = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic ready, done, tmo, reg_rd, reg_wr, busy;
  logic [7:0] rdata, reg_addr, reg_wdata;
  logic [7:0] reg_rdata;
  logic wr_seen, rd_seen, pass_seen, fin, got_tmo;
  logic [7:0] wa, wd;
  int miscompares = 0;
  int compares = 0;

  always #5 i_clk = ~i_clk;
  // Register file answer is a fixed scramble of the address
  assign reg_rdata = reg_addr ^ 8'h5a;

  chbp_if bus ();
  chbp_dev_end i_chbp_dev_end (.i_clk(i_clk), .i_rst(i_rst), .bus(bus),
    .i_strobe_pair_mode(mode), .i_ack_delay_select(dly), .i_svc_pending(pend),
    .i_svc_match_value(match), .i_svc_vector(8'hc3), .i_reg_rdata(reg_rdata),
    .o_reg_rd(reg_rd), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_busy(busy));
  // Short ack wait keeps the miss case quick
  chbp_host_end #(.ACK_WAIT_CYC(32)) i_chbp_host_end (.i_clk(i_clk), .i_rst(i_rst),
    .bus(bus), .i_strobe_pair_mode(mode), .i_req_valid(valid), .i_req_write(wr),
    .i_req_svc(svc), .i_req_addr(addr), .i_req_wdata(wdata), .o_req_ready(ready),
    .o_done(done), .o_timeout(tmo), .o_rdata(rdata));
  chbp_props i_chbp_props (.i_clk(i_clk), .i_rst(i_rst), .cs_n(bus.cs_n),
    .ds_n(bus.ds_n), .rw_n(bus.rw_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n),
    .ack_chain_in_n(bus.ack_chain_in_n), .transfer_ack_n(bus.transfer_ack_n),
    .dev_data_oe(bus.dev_data_oe), .ack_chain_pass_n(bus.ack_chain_pass_n),
    .clock_fwd_out(bus.clock_fwd_out));

  // Latch register strobes and chain passing; a new request clears them
  always @(posedge i_clk) begin
    if (valid === 1'b1) begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
      pass_seen <= 1'b0;
    end else begin
      if (reg_wr === 1'b1) begin
        wr_seen <= 1'b1;
        wa <= reg_addr;
        wd <= reg_wdata;
      end
      if (reg_rd === 1'b1) rd_seen <= 1'b1;
      if (bus.ack_chain_pass_n === 1'b0) pass_seen <= 1'b1;
    end
  end

  task automatic check1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t flag got %b exp %b", $time, g, e);
    end
  endtask

  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL t=%0t byte got %h exp %h", $time, g, e);
    end
  endtask

  // One host request, bounded waits for ready and completion
  task automatic req(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
    repeat (50) begin
      if (ready === 1'b1) break;
      @(posedge i_clk);
      #1;
    end
    check1(ready, 1'b1);
    fin = 1'b0;
    @(posedge i_clk);
    valid <= 1'b1;
    wr <= w;
    svc <= s;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    valid <= 1'b0;
    repeat (100) begin
      @(posedge i_clk);
      #1;
      if (done === 1'b1 || tmo === 1'b1) begin
        fin = 1'b1;
        break;
      end
    end
    got_tmo = tmo;
  endtask

  task automatic t_write(input logic m, input logic dl);
    logic [7:0] a;
    a = 8'h3c + {6'h00, m, dl};
    @(posedge i_clk);
    mode <= m;
    dly <= dl;
    req(1'b1, 1'b0, a, ~a);
    check1(fin, 1'b1);
    check1(got_tmo, 1'b0);
    check1(wr_seen, 1'b1);
    check1(rd_seen, 1'b0);
    check8(wa, a);
    check8(wd, ~a);
  endtask

  task automatic t_read(input logic m, input logic dl);
    logic [7:0] a;
    a = 8'ha1 + {6'h00, m, dl};
    req(1'b0, 1'b0, a, 8'h00);
    check1(fin, 1'b1);
    check1(got_tmo, 1'b0);
    check1(rd_seen, 1'b1);
    check1(wr_seen, 1'b0);
    check1(busy, 1'b0);
    check8(rdata, a ^ 8'h5a);
  endtask

  // Service acknowledge, matching or passed down the chain
  task automatic t_svc(input logic hit);
    @(posedge i_clk);
    pend <= 1'b1;
    match <= hit ? 8'h47 : 8'h48;
    req(1'b0, 1'b1, 8'h47, 8'h00);
    if (hit) begin
      check1(fin, 1'b1);
      check1(got_tmo, 1'b0);
      check8(rdata, 8'hc3);
    end else begin
      check1(got_tmo, 1'b1);
      check1(pass_seen, 1'b1);
      check8(rdata, 8'hc3);
    end
    pend <= 1'b0;
  endtask

  task automatic summarize;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    check1(bus.transfer_ack_n, 1'b1);
    check1(bus.ack_chain_pass_n, 1'b1);
    // Both handshake styles, both ack delays, back to back
    for (int i = 0; i < 4; i++) begin
      t_write(i[1], i[0]);
      t_read(i[1], i[0]);
    end
    t_svc(1'b1);
    t_svc(1'b0);
    summarize;
  end

  // About ten requests of a few dozen cycles; far beyond that is a hang
  initial begin
    #100000;
    miscompares++;
    summarize;
  end
endmodule
